// file: src/osc_ctrl_pkg.sv
// Constants for the programmable oscillator control block.
// Assumes an AXI4-Lite master on mclk and seven serially loaded clock generators.
// Notes on behaviour
// - Seven independent programmable clock outputs, each 6 to 200 MHz.
// - VCO divider word sits in bits 8:0, valid 4 to 511.
// - Reference divider word sits in bits 15:9, valid 1 to 127.
// - Output divider select bits 18:16 decode to 10,2,8,4,5,7,3,6.
// - Frequency is 48*(vco+8) over (ref+2) times output divisor.
// - Divider values are shifted into each generator's serial data pins.
// - Software reaches generators only through the oscillator setting registers.
// - Power-on defaults: 100, 40, 25, 50, 25, 70, 24 MHz.
// - A 50 MHz static memory clock is derived from output 0; the code halves output 0 seen on mclk, so at most 25 MHz at CLK_MHZ 100.
package osc_ctrl_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int NUM_OSC = 7;
    localparam logic [7:0] OSC_BASE_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h1C;
    localparam int SETTING_WIDTH = 19;
    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int VCO_DIV_LSB = 0;
    localparam int VCO_DIV_MSB = 8;
    localparam int REF_DIV_LSB = 9;
    localparam int REF_DIV_MSB = 15;
    localparam int OUT_SEL_LSB = 16;
    localparam int OUT_SEL_MSB = 18;
    localparam logic [8:0] VCO_DIV_MIN = 9'h004;
    localparam logic [6:0] REF_DIV_MIN = 7'h01;
    // Defaults: output select, ref divider, vco divider, all inside the legal ranges
    // 100: 48*(17+8)/(4+2)/2 ; 40: 48*(7+8)/(7+2)/2 ; 25: 48*(17+8)/(6+2)/6
    // 50: 48*(17+8)/(4+2)/4 ; 70: 48*(27+8)/(2+2)/6 ; 24: 48*(4+8)/(10+2)/2
    localparam logic [18:0] OSC_RESET [NUM_OSC] = '{
        19'h10811, 19'h10E07, 19'h70C11, 19'h30811, 19'h70C11, 19'h7041B, 19'h11404
    };
    // ----------------------------------------------------------------
    // Serial timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SER_HALF_NS = 100;
    localparam int SER_HALF_CYC = (SER_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] SER_BITS = 5'h13;
    localparam int HALF_W = 8;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : osc_ctrl_pkg

// file: src/osc_load_if.sv
// Load request and busy between the register front end and the serial loaders.
// Assumes one mclk domain.
interface osc_load_if;
    import osc_ctrl_pkg::*;
    logic [NUM_OSC-1:0] start;
    logic [NUM_OSC-1:0] busy;
    logic [SETTING_WIDTH-1:0] word [NUM_OSC];
    modport ctrl (output start, output word, input busy);
    modport loader (input start, input word, output busy);
endinterface : osc_load_if

// file: src/osc_serial_loader.sv
// Serial shifters: one per generator, MSB first, with data/clock/strobe pins.
// Assumes generators latch data on rising serial clock and load on strobe.
module osc_serial_loader
    import osc_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    osc_load_if.loader lif,
    output logic [NUM_OSC-1:0] ser_data,
    output logic [NUM_OSC-1:0] ser_clk,
    output logic [NUM_OSC-1:0] ser_strobe
);
    for (genvar g = 0; g < NUM_OSC; g++) begin : g_osc
        logic [SETTING_WIDTH-1:0] sh_reg;
        logic [4:0] cnt_reg;
        logic [HALF_W-1:0] tick_reg;
        logic phase_reg;
        logic act_reg;
        logic strobe_reg;
        logic pend_reg;
        wire tick_done = (tick_reg == HALF_W'(SER_HALF_CYC - 1));
        // Restart after the current word if a new write lands mid-shift or on the strobe
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                sh_reg <= '0;
                cnt_reg <= 5'h00;
                tick_reg <= '0;
                phase_reg <= 1'b0;
                act_reg <= 1'b0;
                strobe_reg <= 1'b0;
                pend_reg <= 1'b0;
            end else begin
                strobe_reg <= 1'b0;
                if (lif.start[g] && (act_reg || strobe_reg)) begin
                    pend_reg <= 1'b1;
                end
                if (!act_reg && (lif.start[g] || pend_reg) && !strobe_reg) begin
                    sh_reg <= lif.word[g];
                    cnt_reg <= SER_BITS;
                    tick_reg <= '0;
                    phase_reg <= 1'b0;
                    act_reg <= 1'b1;
                    pend_reg <= 1'b0;
                end else if (act_reg) begin
                    tick_reg <= tick_done ? '0 : tick_reg + 1'b1;
                    if (tick_done) begin
                        phase_reg <= ~phase_reg;
                        if (phase_reg) begin
                            sh_reg <= {sh_reg[SETTING_WIDTH-2:0], 1'b0};
                            cnt_reg <= cnt_reg - 5'h01;
                            if (cnt_reg == 5'h01) begin
                                act_reg <= 1'b0;
                                strobe_reg <= 1'b1;
                            end
                        end
                    end
                end
            end
        end
        assign ser_data[g] = act_reg & sh_reg[SETTING_WIDTH-1];
        assign ser_clk[g] = act_reg & phase_reg;
        assign ser_strobe[g] = strobe_reg;
        assign lif.busy[g] = act_reg | pend_reg | strobe_reg;
    end
endmodule : osc_serial_loader

// file: src/programmable_oscillator_control.sv
// Top of the oscillator control: AXI4-Lite registers, loaders, memory clock.
// Assumes an AXI4-Lite master on mclk and generator output 0 sampled on mclk.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
module programmable_oscillator_control
    import osc_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic programmable_clock_out0,
    output logic [NUM_OSC-1:0] osc_ser_data,
    output logic [NUM_OSC-1:0] osc_ser_clk,
    output logic [NUM_OSC-1:0] osc_ser_strobe,
    output logic static_memory_clock
);
    // ----------------------------------------------------------------
    // Register storage and loader link
    // ----------------------------------------------------------------
    osc_load_if lif ();
    logic [SETTING_WIDTH-1:0] osc_reg [NUM_OSC];
    logic [NUM_OSC-1:0] start_reg;
    logic init_reg;
    logic [7:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic [NUM_OSC-1:0] ser_data_w;
    logic [NUM_OSC-1:0] ser_clk_w;
    logic [NUM_OSC-1:0] ser_strobe_w;
    logic [NUM_OSC-1:0] ser_data_reg;
    logic [NUM_OSC-1:0] ser_clk_reg;
    logic [NUM_OSC-1:0] ser_strobe_reg;
    logic clk0_s1_reg;
    logic clk0_s2_reg;
    logic clk0_d_reg;
    logic smc_reg;

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [5:0] w_index = awaddr_reg[7:2];
    wire w_is_osc = (awaddr_reg[1:0] == 2'b00) && (w_index < 6'(NUM_OSC));
    wire w_is_status = (awaddr_reg == STATUS_OFFSET);
    wire w_ok = w_is_osc || w_is_status;
    // Range check on vco divider word
    wire vco_div_ok = (wdata_reg[VCO_DIV_MSB:VCO_DIV_LSB] >= VCO_DIV_MIN);
    // Range check on reference divider word
    wire ref_div_ok = (wdata_reg[REF_DIV_MSB:REF_DIV_LSB] >= REF_DIV_MIN);
    wire full_strb = (wstrb_reg[2:0] == 3'b111);
    wire accept_osc = do_write && w_is_osc && vco_div_ok && ref_div_ok && full_strb;
    // Channel state after this edge, so the readies can come from flops
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_held_next = aw_take || (aw_held_reg && !do_write);
    wire w_held_next = w_take || (w_held_reg && !do_write);
    wire bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);

    // Address and data captured independently, answered together
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            // Each ready only while its own channel holds nothing and no answer waits
            s_axi_awready <= !aw_held_next && !bvalid_next;
            s_axi_wready <= !w_held_next && !bvalid_next;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (w_ok && (w_is_status || accept_osc)) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Oscillator setting registers
    // ----------------------------------------------------------------
    // Only these registers feed the serial loaders
    for (genvar g = 0; g < NUM_OSC; g++) begin : g_reg
        wire hit = accept_osc && (w_index == 6'(g));
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                osc_reg[g] <= OSC_RESET[g];
                start_reg[g] <= 1'b0;
            end else begin
                if (hit) begin
                    osc_reg[g] <= wdata_reg[SETTING_WIDTH-1:0];
                end
                // First cycle after reset loads defaults
                start_reg[g] <= hit || init_reg;
            end
        end
        assign lif.word[g] = osc_reg[g];
    end
    assign lif.start = start_reg;

    // One-shot power-on load
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            init_reg <= 1'b1;
        end else begin
            init_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    wire [5:0] r_index = s_axi_araddr[7:2];
    wire r_is_osc = (s_axi_araddr[1:0] == 2'b00) && (r_index < 6'(NUM_OSC));
    wire r_is_status = (s_axi_araddr == STATUS_OFFSET);
    wire [31:0] r_osc_data = r_is_osc ? {13'h0000, osc_reg[3'(r_index)]} : 32'h0000_0000;
    wire [31:0] r_data = r_is_status ? {25'h0000000, lif.busy} : r_osc_data;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);

    // Read answered one cycle after address is taken
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            // One read in flight: ready again once the answer is taken
            s_axi_arready <= !rvalid_next;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= r_data;
                s_axi_rresp <= (r_is_osc || r_is_status) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial loaders and registered pins
    // ----------------------------------------------------------------
    // Serial programming of each generator
    osc_serial_loader u_loader (
        .mclk(mclk),
        .rst(rst),
        .lif(lif.loader),
        .ser_data(ser_data_w),
        .ser_clk(ser_clk_w),
        .ser_strobe(ser_strobe_w)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ser_data_reg <= '0;
            ser_clk_reg <= '0;
            ser_strobe_reg <= '0;
        end else begin
            ser_data_reg <= ser_data_w;
            ser_clk_reg <= ser_clk_w;
            ser_strobe_reg <= ser_strobe_w;
        end
    end
    assign osc_ser_data = ser_data_reg;
    assign osc_ser_clk = ser_clk_reg;
    assign osc_ser_strobe = ser_strobe_reg;

    // ----------------------------------------------------------------
    // Static memory clock
    // ----------------------------------------------------------------
    // Halve output 0 by toggling on its synchronised rising edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk0_s1_reg <= 1'b0;
            clk0_s2_reg <= 1'b0;
            clk0_d_reg <= 1'b0;
            smc_reg <= 1'b0;
        end else begin
            clk0_s1_reg <= programmable_clock_out0;
            clk0_s2_reg <= clk0_s1_reg;
            clk0_d_reg <= clk0_s2_reg;
            if (clk0_s2_reg && !clk0_d_reg) begin
                smc_reg <= ~smc_reg;
            end
        end
    end
    assign static_memory_clock = smc_reg;
    // Divisor decode and frequency are the generators' own; stored fields pass unchanged
endmodule : programmable_oscillator_control

// file: testbench/osc_ctrl_props.sv
// Checker for the oscillator control top: bus answers and serial loading.
// Assumes it is bound to the top and sees only its ports.
module osc_ctrl_props
    import osc_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [NUM_OSC-1:0] osc_ser_data,
    input wire logic [NUM_OSC-1:0] osc_ser_clk,
    input wire logic [NUM_OSC-1:0] osc_ser_strobe,
    input wire logic static_memory_clock
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [7:0] aw_reg;
    // Address of the last accepted write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_reg <= 8'hFF;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_reg <= s_axi_awaddr;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_clk_high; $rose(osc_ser_clk[0]) |-> ##9 osc_ser_clk[0] ##1 !osc_ser_clk[0]; endproperty
    a_clk_high: assert property (p_clk_high) else $error("serial clock high time wrong");
    property p_data_hold; osc_ser_clk[0] && $past(osc_ser_clk[0]) |-> $stable(osc_ser_data[0]); endproperty
    a_data_hold: assert property (p_data_hold) else $error("serial data moved while clock high");
    property p_strobe_pulse; osc_ser_strobe[0] |-> !osc_ser_clk[0] ##1 !osc_ser_strobe[0]; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("load strobe malformed");
    property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_no_aw_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_no_aw_busy: assert property (p_no_aw_busy) else $error("address taken while answer pending");
    property p_write_load;
        $rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY && aw_reg == OSC_BASE_OFFSET |-> ##[1:900] osc_ser_strobe[0];
    endproperty
    a_write_load: assert property (p_write_load) else $error("write did not reload generator");
    property p_smc; $changed(static_memory_clock) |=> $stable(static_memory_clock); endproperty
    a_smc: assert property (p_smc) else $error("memory clock toggles too fast");
    property p_refuse; $rose(s_axi_bvalid) && aw_reg == 8'h20 |-> s_axi_bresp == RESP_SLVERR; endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped write accepted");
    c_load6: cover property (osc_ser_strobe[6]);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_read: cover property (s_axi_rvalid);
endmodule : osc_ctrl_props
bind programmable_oscillator_control osc_ctrl_props i_osc_ctrl_props (.*);

// file: testbench/osc_gen_model.sv
// Behavioural model of the seven serially loaded clock generators.
// Assumes data sampled on serial clock rise and word taken on the strobe.
module osc_gen_model
    import osc_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic [NUM_OSC-1:0] ser_data,
    input wire logic [NUM_OSC-1:0] ser_clk,
    input wire logic [NUM_OSC-1:0] ser_strobe,
    output logic clk0_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SETTING_WIDTH-1:0] shift_reg [NUM_OSC];
    logic [SETTING_WIDTH-1:0] loaded [NUM_OSC];
    logic [NUM_OSC-1:0] clk_q = '0;
    int bits [NUM_OSC] = '{default: 0};
    int last_bits [NUM_OSC] = '{default: 0};
    // Generator 0 output at 25 MHz, below the sampling limit
    initial begin
        clk0_out = 1'b0;
        forever #20 clk0_out = ~clk0_out;
    end
    always @(posedge mclk) begin
        for (int g = 0; g < NUM_OSC; g++) begin
            if (ser_clk[g] && !clk_q[g]) begin
                shift_reg[g] <= {shift_reg[g][SETTING_WIDTH-2:0], ser_data[g]};
                bits[g] <= bits[g] + 1;
            end
            if (ser_strobe[g]) begin
                loaded[g] <= shift_reg[g];
                last_bits[g] <= bits[g];
                bits[g] <= 0;
            end
        end
        clk_q <= ser_clk;
    end
endmodule : osc_gen_model

// file: testbench/programmable_oscillator_control_bench.sv
// Self-checking bench: AXI4-Lite tasks, generator model, frequency checks.
// Assumes the checker is bound by its own file.
module programmable_oscillator_control_bench
    import osc_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, programmable_clock_out0, static_memory_clock;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [NUM_OSC-1:0] osc_ser_data, osc_ser_clk, osc_ser_strobe;
    logic [18:0] w;
    int exp_mhz [NUM_OSC] = '{100, 40, 25, 50, 25, 70, 24};
    int n_mismatch = 0;
    int compares = 0;
    int n_c0 = 0;
    int n_smc = 0;
    programmable_oscillator_control i_programmable_oscillator_control (.*);
    osc_gen_model i_osc_gen_model (.mclk(mclk), .ser_data(osc_ser_data), .ser_clk(osc_ser_clk),
        .ser_strobe(osc_ser_strobe), .clk0_out(programmable_clock_out0));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge programmable_clock_out0) n_c0++;
    always @(posedge static_memory_clock) n_smc++;
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge mclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge mclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge mclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    // Waits for a generator to hold a word, then compares it
    task automatic wait_word(input int g, input logic [18:0] v);
        int t;
        t = 0;
        while (i_osc_gen_model.loaded[g] !== v && t < 2000) begin
            @(posedge mclk);
            t++;
        end
        check(32'(i_osc_gen_model.loaded[g]), 32'(v));
        check(32'(i_osc_gen_model.last_bits[g]), 32'h13);
    endtask : wait_word
    function automatic int mhz(input logic [18:0] v);
        int dv [8] = '{10, 2, 8, 4, 5, 7, 3, 6};
        return 48 * (v[8:0] + 8) / ((v[15:9] + 2) * dv[v[18:16]]);
    endfunction : mhz
    task automatic complete_run();
        $display("Mismatches %0d in %0d compares", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int g = 0; g < NUM_OSC; g++) begin
            wait_word(g, OSC_RESET[g]);
            check(mhz(i_osc_gen_model.loaded[g]), exp_mhz[g]);
            axi_read(8'(4 * g), rd, rsp);
            check(rd, {13'h0000, i_osc_gen_model.loaded[g]});
        end
        // status idle, writes to it answered and ignored
        axi_read(STATUS_OFFSET, rd, rsp);
        check(rd, 32'h0000_0000);
        check(rsp, RESP_OKAY);
        axi_write(STATUS_OFFSET, 32'h0000_007F, rsp);
        check(rsp, RESP_OKAY);
        // refused writes leave the word alone
        axi_write(8'h08, 32'h10803, rsp);
        check(rsp, RESP_SLVERR);
        axi_write(8'h08, 32'h10011, rsp);
        check(rsp, RESP_SLVERR);
        axi_write(8'h20, 32'h10811, rsp);
        check(rsp, RESP_SLVERR);
        s_axi_wstrb <= 4'h3;
        axi_write(8'h08, 32'h10811, rsp);
        check(rsp, RESP_SLVERR);
        s_axi_wstrb <= 4'hF;
        axi_read(8'h24, rd, rsp);
        check(rd, 32'h0000_0000);
        check(rsp, RESP_SLVERR);
        axi_read(8'h08, rd, rsp);
        check(rd, {13'h0000, OSC_RESET[2]});
        // every output select code written and shifted out
        for (int k = 0; k < 8; k++) begin
            w = {k[2:0], 7'(k * 18 + 1), 9'(k * 72 + 4)};
            axi_write(8'(4 * (k % 7)), {13'h0000, w}, rsp);
            check(rsp, RESP_OKAY);
            wait_word(k % 7, w);
        end
        // write during a shift: both words go out, latest last
        axi_write(8'h14, 32'h7FFFF, rsp);
        check(rsp, RESP_OKAY);
        axi_write(8'h14, 32'h00204, rsp);
        check(rsp, RESP_OKAY);
        axi_read(STATUS_OFFSET, rd, rsp);
        check(rd, 32'h0000_0020);
        wait_word(5, 19'h7FFFF);
        wait_word(5, 19'h00204);
        axi_read(STATUS_OFFSET, rd, rsp);
        check(rd, 32'h0000_0000);
        // memory clock is half of generator 0
        check(32'((n_c0 - 2 * n_smc) inside {[-4:4]}), 32'h1);
        complete_run();
    end
    // Watchdog well beyond the expected run of about 40 us
    initial begin
        #400us;
        n_mismatch++;
        complete_run();
    end
endmodule : programmable_oscillator_control_bench
